/* gpc_pkg.sv */
// Package with the register map, reset values, bit positions and pad types of the port block.
package gpc_pkg;
    // Register byte offsets on the AXI4-Lite bus.
    localparam int unsigned ADDR_W = 6;
    localparam logic [5:0] OFF_FP_PINS = 6'h00;
    localparam logic [5:0] OFF_FP_LATCH = 6'h04;
    localparam logic [5:0] OFF_FP_DIR = 6'h08;
    localparam logic [5:0] OFF_ANA_LOW = 6'h0C;
    localparam logic [5:0] OFF_CMP_CTRL = 6'h10;
    localparam logic [5:0] OFF_CVR_CTRL = 6'h14;
    localparam logic [5:0] OFF_SP_PINS = 6'h18;
    localparam logic [5:0] OFF_SP_LATCH = 6'h1C;
    localparam logic [5:0] OFF_SP_DIR = 6'h20;
    localparam logic [5:0] OFF_INT_ONE = 6'h24;
    localparam logic [5:0] OFF_INT_TWO = 6'h28;
    localparam logic [5:0] OFF_OSC_MODE = 6'h2C;
    localparam logic [5:0] OFF_SP_ANA = 6'h30;

    // Reset values.
    localparam logic [7:0] RST_FP_DIR = 8'hEF;
    localparam logic [7:0] RST_SP_DIR = 8'hFF;
    localparam logic [7:0] RST_ANA_LOW = 8'h00;
    localparam logic [7:0] RST_SP_ANA = 8'h00;
    localparam logic [7:0] RST_INT_TWO = 8'h80;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [1:0] RST_OSC_MODE = 2'h0;

    // Field positions and masks.
    localparam int unsigned BIT_PULLUP_N = 7;
    localparam int unsigned BIT_CHANGE_FLAG = 0;
    localparam int unsigned BIT_AN4_DIG = 4;
    localparam int unsigned PIN_SS = 5;
    localparam int unsigned PIN_CLKOUT = 6;
    localparam int unsigned PIN_OSCIN = 7;
    localparam logic [7:0] FP_IMPL_MASK = 8'hEF;
    localparam logic [7:0] SP_ANA_MASK = 8'h0F;

    // The cycle clock is the core clock divided by four.
    localparam int unsigned CYCLE_DIV = 4;
    localparam int unsigned DIV_W = $clog2(CYCLE_DIV);

    // AXI response codes.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Oscillator pin usage modes, in register code order.
    typedef enum logic [1:0] {
        OSC_INTERNAL,
        OSC_HS,
        OSC_RC,
        OSC_EC
    } gpc_osc_e;

    // Output level and drive enable of one 8-bit port.
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } gpc_pad_s;
endpackage

/* gpc_port.sv */
// Two 8-bit general-purpose ports, pull-ups and change detection on the second port only, and an AXI4-Lite register file.
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module gpc_port #(
    parameter int unsigned PORT_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [gpc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [gpc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] first_port_pins_in,
    output gpc_pkg::gpc_pad_s first_port_pad,
    input wire logic [7:0] second_port_pins_in,
    output gpc_pkg::gpc_pad_s second_port_pad,
    output logic [7:0] second_port_pullup,
    input wire logic mem_to_mem_move,
    input wire logic remap_pin_two_drive,
    input wire logic remap_pin_two_out,
    output logic remap_pin_two_in,
    output logic serial1_slave_select,
    output logic analog_channel_four_en,
    output logic osc_feedback_active,
    output logic wake_request
);
    // The pin map below is fixed to eight bits per port; any other width is refused at elaboration.
    if (PORT_W != 8) begin : g_width_check
        $error("gpc_port supports only PORT_W = 8");
    end

    // Register state.
    logic [7:0] fp_latch_r;
    logic [7:0] fp_dir_r;
    logic [7:0] ana_low_r;
    logic [7:0] cmp_ctrl_r;
    logic [7:0] cvr_ctrl_r;
    logic [7:0] sp_latch_r;
    logic [7:0] sp_dir_r;
    logic [7:0] sp_ana_r;
    logic [7:0] int_two_r;
    logic [1:0] osc_mode_r;
    logic change_flag_r;
    logic change_flag_nxt;
    logic [3:0] snap_r;
    logic [gpc_pkg::DIV_W-1:0] div_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    gpc_pkg::gpc_pad_s fp_pad_r;
    gpc_pkg::gpc_pad_s sp_pad_r;
    logic [7:0] sp_pullup_r;
    logic ss_r;
    logic rp2_in_r;

    // Two-stage synchronisers for both ports; only the second stage is read.
    logic [7:0] fp_meta_r;
    logic [7:0] fp_sync_r;
    logic [7:0] sp_meta_r;
    logic [7:0] sp_sync_r;
    always_ff @(posedge aclk) begin
        fp_meta_r <= first_port_pins_in;
        fp_sync_r <= fp_meta_r;
        sp_meta_r <= second_port_pins_in;
        sp_sync_r <= sp_meta_r;
    end

    // Write channel: address and data are taken together, one write outstanding.
    logic wr_go;
    logic wr_en;
    logic [5:0] wa;
    logic [7:0] wd;
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign wr_en = wr_go && s_axi_wstrb[0];
    assign wa = s_axi_awaddr;
    assign wd = s_axi_wdata[7:0];
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;

    // Per-register write strobes.
    // A write with byte lane 0 off still answers but changes nothing.
    logic w_fp;
    logic w_fp_latch;
    logic w_sp;
    logic w_sp_latch;
    logic w_int_one;
    logic w_fp_dir;
    logic w_ana_low;
    logic w_cmp_ctrl;
    logic w_cvr_ctrl;
    logic w_sp_dir;
    logic w_sp_ana;
    logic w_int_two;
    logic w_osc_mode;
    logic wr_hit;
    assign w_fp = wr_en && (wa == gpc_pkg::OFF_FP_PINS);
    assign w_fp_latch = wr_en && (wa == gpc_pkg::OFF_FP_LATCH);
    assign w_sp = wr_en && (wa == gpc_pkg::OFF_SP_PINS);
    assign w_sp_latch = wr_en && (wa == gpc_pkg::OFF_SP_LATCH);
    assign w_int_one = wr_en && (wa == gpc_pkg::OFF_INT_ONE);
    assign w_fp_dir = wr_en && (wa == gpc_pkg::OFF_FP_DIR);
    assign w_ana_low = wr_en && (wa == gpc_pkg::OFF_ANA_LOW);
    assign w_cmp_ctrl = wr_en && (wa == gpc_pkg::OFF_CMP_CTRL);
    assign w_cvr_ctrl = wr_en && (wa == gpc_pkg::OFF_CVR_CTRL);
    assign w_sp_dir = wr_en && (wa == gpc_pkg::OFF_SP_DIR);
    assign w_sp_ana = wr_en && (wa == gpc_pkg::OFF_SP_ANA);
    assign w_int_two = wr_en && (wa == gpc_pkg::OFF_INT_TWO);
    assign w_osc_mode = wr_en && (wa == gpc_pkg::OFF_OSC_MODE);
    assign wr_hit = (wa == gpc_pkg::OFF_FP_PINS) || (wa == gpc_pkg::OFF_FP_LATCH) || (wa == gpc_pkg::OFF_FP_DIR)
        || (wa == gpc_pkg::OFF_ANA_LOW) || (wa == gpc_pkg::OFF_CMP_CTRL) || (wa == gpc_pkg::OFF_CVR_CTRL)
        || (wa == gpc_pkg::OFF_SP_PINS) || (wa == gpc_pkg::OFF_SP_LATCH) || (wa == gpc_pkg::OFF_SP_DIR)
        || (wa == gpc_pkg::OFF_INT_ONE) || (wa == gpc_pkg::OFF_INT_TWO) || (wa == gpc_pkg::OFF_OSC_MODE)
        || (wa == gpc_pkg::OFF_SP_ANA);

    // Register storage; writing a pin register lands in its latch.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fp_latch_r <= gpc_pkg::RST_ZERO;
            fp_dir_r <= gpc_pkg::RST_FP_DIR;
            ana_low_r <= gpc_pkg::RST_ANA_LOW;
            cmp_ctrl_r <= gpc_pkg::RST_ZERO;
            cvr_ctrl_r <= gpc_pkg::RST_ZERO;
            sp_latch_r <= gpc_pkg::RST_ZERO;
            sp_dir_r <= gpc_pkg::RST_SP_DIR;
            sp_ana_r <= gpc_pkg::RST_SP_ANA;
            int_two_r <= gpc_pkg::RST_INT_TWO;
            osc_mode_r <= gpc_pkg::RST_OSC_MODE;
        end else begin
            if (w_fp || w_fp_latch) begin
                fp_latch_r <= wd & gpc_pkg::FP_IMPL_MASK;
            end
            if (w_fp_dir) begin
                fp_dir_r <= wd & gpc_pkg::FP_IMPL_MASK;
            end
            if (w_ana_low) begin
                ana_low_r <= wd;
            end
            if (w_cmp_ctrl) begin
                cmp_ctrl_r <= wd;
            end
            if (w_cvr_ctrl) begin
                cvr_ctrl_r <= wd;
            end
            if (w_sp || w_sp_latch) begin
                sp_latch_r <= wd;
            end
            if (w_sp_dir) begin
                sp_dir_r <= wd;
            end
            if (w_sp_ana) begin
                sp_ana_r <= wd & gpc_pkg::SP_ANA_MASK;
            end
            if (w_int_two) begin
                int_two_r <= wd;
            end
            if (w_osc_mode) begin
                osc_mode_r <= wd[1:0];
            end
        end
    end

    // Write response.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= gpc_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? gpc_pkg::RESP_OKAY : gpc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;

    // Oscillator mode decode for pins 6 and 7.
    gpc_pkg::gpc_osc_e osc_mode;
    logic clk_out_mode;
    logic osc_hs;
    logic osc_uses_pins;
    assign osc_mode = gpc_pkg::gpc_osc_e'(osc_mode_r);
    assign clk_out_mode = (osc_mode == gpc_pkg::OSC_RC) || (osc_mode == gpc_pkg::OSC_EC);
    assign osc_hs = (osc_mode == gpc_pkg::OSC_HS);
    assign osc_uses_pins = (osc_mode != gpc_pkg::OSC_INTERNAL);

    // Digital read view: analog pins, oscillator pins and bit 4 read zero.
    logic an4_enabled;
    logic [7:0] fp_rd_mask;
    logic [7:0] fp_rd;
    logic [7:0] sp_rd;
    logic [7:0] sp_dig_mask;
    assign an4_enabled = !ana_low_r[gpc_pkg::BIT_AN4_DIG];
    assign fp_rd_mask = gpc_pkg::FP_IMPL_MASK & ~({osc_uses_pins, osc_uses_pins, an4_enabled, 5'h00});
    assign fp_rd = fp_sync_r & fp_rd_mask;
    // A clear analog bit keeps the low pin reading zero; the upper four pins are always digital.
    assign sp_dig_mask = sp_ana_r | ~gpc_pkg::SP_ANA_MASK;
    assign sp_rd = sp_sync_r & sp_dig_mask;

    // Read channel: one read outstanding, data registered.
    logic rd_go;
    logic [5:0] ra;
    logic [7:0] rd_byte;
    logic rd_hit;
    logic rd_sp;
    assign rd_go = s_axi_arvalid && !rvalid_r;
    assign ra = s_axi_araddr;
    assign s_axi_arready = !rvalid_r;
    assign rd_sp = rd_go && (ra == gpc_pkg::OFF_SP_PINS);
    assign rd_byte =
        ({8{ra == gpc_pkg::OFF_FP_PINS}} & fp_rd)
        | ({8{ra == gpc_pkg::OFF_FP_LATCH}} & fp_latch_r)
        | ({8{ra == gpc_pkg::OFF_FP_DIR}} & fp_dir_r)
        | ({8{ra == gpc_pkg::OFF_ANA_LOW}} & ana_low_r)
        | ({8{ra == gpc_pkg::OFF_CMP_CTRL}} & cmp_ctrl_r)
        | ({8{ra == gpc_pkg::OFF_CVR_CTRL}} & cvr_ctrl_r)
        | ({8{ra == gpc_pkg::OFF_SP_PINS}} & sp_rd)
        | ({8{ra == gpc_pkg::OFF_SP_LATCH}} & sp_latch_r)
        | ({8{ra == gpc_pkg::OFF_SP_DIR}} & sp_dir_r)
        | ({8{ra == gpc_pkg::OFF_INT_ONE}} & {7'h00, change_flag_r})
        | ({8{ra == gpc_pkg::OFF_INT_TWO}} & int_two_r)
        | ({8{ra == gpc_pkg::OFF_OSC_MODE}} & {6'h00, osc_mode_r})
        | ({8{ra == gpc_pkg::OFF_SP_ANA}} & sp_ana_r);
    assign rd_hit = (ra == gpc_pkg::OFF_FP_PINS) || (ra == gpc_pkg::OFF_FP_LATCH) || (ra == gpc_pkg::OFF_FP_DIR)
        || (ra == gpc_pkg::OFF_ANA_LOW) || (ra == gpc_pkg::OFF_CMP_CTRL) || (ra == gpc_pkg::OFF_CVR_CTRL)
        || (ra == gpc_pkg::OFF_SP_PINS) || (ra == gpc_pkg::OFF_SP_LATCH) || (ra == gpc_pkg::OFF_SP_DIR)
        || (ra == gpc_pkg::OFF_INT_ONE) || (ra == gpc_pkg::OFF_INT_TWO) || (ra == gpc_pkg::OFF_OSC_MODE)
        || (ra == gpc_pkg::OFF_SP_ANA);

    // Read data and response hold until the master takes them.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= gpc_pkg::RESP_OKAY;
        end else if (rd_go) begin
            rvalid_r <= 1'b1;
            rdata_r <= {24'h00_0000, rd_byte};
            rresp_r <= rd_hit ? gpc_pkg::RESP_OKAY : gpc_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Change detection on the upper four pins; outputs and analog pins never compare.
    logic port_touch;
    logic [3:0] eligible;
    logic mismatch;
    logic flag_clear;
    assign port_touch = (rd_sp || w_sp || w_sp_latch) && !mem_to_mem_move;
    assign eligible = sp_dir_r[7:4];
    assign mismatch = |((sp_sync_r[7:4] ^ snap_r) & eligible);
    assign flag_clear = w_int_one && !wd[gpc_pkg::BIT_CHANGE_FLAG];
    // A live mismatch overrides a clear in the same cycle, so no change is lost.
    assign change_flag_nxt = mismatch || (change_flag_r && !flag_clear);

    // The snapshot is retaken on each port access outside a memory move; the mismatch it ends drops one cycle later.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            snap_r <= 4'h0;
            change_flag_r <= 1'b0;
        end else begin
            if (port_touch) begin
                snap_r <= sp_sync_r[7:4];
            end
            change_flag_r <= change_flag_nxt;
        end
    end

    // Cycle clock divider, free running.
    // It never stops, so the clock output keeps no phase tied to mode changes.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    // Pad drive for the first port: direction bits rule, pins 5 to 7 have alternates.
    gpc_pkg::gpc_pad_s fp_pad_nxt;
    logic rp2_drive;
    assign rp2_drive = remap_pin_two_drive && !fp_dir_r[gpc_pkg::PIN_SS];
    always_comb begin
        fp_pad_nxt.out = fp_latch_r;
        fp_pad_nxt.oe = ~fp_dir_r & gpc_pkg::FP_IMPL_MASK;
        if (rp2_drive) begin
            fp_pad_nxt.out[gpc_pkg::PIN_SS] = remap_pin_two_out;
        end
        if (clk_out_mode) begin
            fp_pad_nxt.out[gpc_pkg::PIN_CLKOUT] = div_r[gpc_pkg::DIV_W-1];
            fp_pad_nxt.oe[gpc_pkg::PIN_CLKOUT] = 1'b1;
        end else if (osc_hs) begin
            fp_pad_nxt.out[gpc_pkg::PIN_CLKOUT] = 1'b0;
            fp_pad_nxt.oe[gpc_pkg::PIN_CLKOUT] = 1'b0;
        end
        if (osc_uses_pins) begin
            fp_pad_nxt.out[gpc_pkg::PIN_OSCIN] = 1'b0;
            fp_pad_nxt.oe[gpc_pkg::PIN_OSCIN] = 1'b0;
        end
    end

    // Pads, pull-ups, slave select and the remapped input are registered to keep the pins glitch free.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fp_pad_r <= '0;
            sp_pad_r <= '0;
            sp_pullup_r <= 8'h00;
            ss_r <= 1'b1;
            rp2_in_r <= 1'b0;
        end else begin
            fp_pad_r <= fp_pad_nxt;
            sp_pad_r.out <= sp_latch_r;
            sp_pad_r.oe <= ~sp_dir_r;
            sp_pullup_r <= {8{!int_two_r[gpc_pkg::BIT_PULLUP_N]}} & sp_dir_r;
            ss_r <= fp_dir_r[gpc_pkg::PIN_SS] ? fp_sync_r[gpc_pkg::PIN_SS] : 1'b1;
            rp2_in_r <= fp_dir_r[gpc_pkg::PIN_SS] & fp_sync_r[gpc_pkg::PIN_SS];
        end
    end

    // Slave select idles high while pin 5 is an output, so the serial block never sees a false select.
    assign first_port_pad = fp_pad_r;
    assign second_port_pad = sp_pad_r;
    assign second_port_pullup = sp_pullup_r;
    assign serial1_slave_select = ss_r;
    assign remap_pin_two_in = rp2_in_r;
    assign analog_channel_four_en = an4_enabled;
    assign osc_feedback_active = osc_hs;
    // The sticky flag doubles as the wake request, so sleep and idle both end on it.
    assign wake_request = change_flag_r;
endmodule // gpc_port

/* gpc_port_properties.sv */
// Concurrent checks on the ports of the port block.
`timescale 1ns/1ps
module gpc_port_properties (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_awready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire gpc_pkg::gpc_pad_s first_port_pad,
    input wire gpc_pkg::gpc_pad_s second_port_pad,
    input wire logic [7:0] second_port_pullup,
    input wire logic osc_feedback_active,
    input wire logic wake_request
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Handshake steps that start the two kinds of transfer.
    sequence s_write_taken;
        s_axi_awvalid && s_axi_wvalid && s_axi_awready;
    endsequence
    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // Bus answers and their holding, which keep the master from losing a response, and the zero upper read bits.
    AST_WRITE_ANSWER: assert property (s_write_taken |=> s_axi_bvalid) else $error("write not answered");
    AST_READ_ANSWER: assert property (s_read_taken |=> s_axi_rvalid) else $error("read not answered");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_R_UPPER: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    // Pin rules, some only under a condition or at reset release, and the stickiness of the change flag.
    AST_PULLUP_OUT: assert property ((second_port_pullup & second_port_pad.oe) == 8'h00)
        else $error("pull-up on an output pin");
    AST_BIT4_HIGHZ: assert property (!first_port_pad.oe[4])
        else $error("unimplemented pin driven");
    AST_OSC_IN: assert property (osc_feedback_active && $past(osc_feedback_active) |-> !first_port_pad.oe[7])
        else $error("oscillator input driven");
    AST_PULLUP_RST: assert property ($rose(aresetn) |-> second_port_pullup == 8'h00)
        else $error("pull-ups on after reset");
    AST_FLAG_STICKY: assert property (wake_request && !s_axi_awready |=> wake_request)
        else $error("change flag lost");
endmodule // gpc_port_properties
bind gpc_port gpc_port_properties i_gpc_port_properties (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid), .s_axi_awready(s_axi_awready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .first_port_pad(first_port_pad),
    .second_port_pad(second_port_pad), .second_port_pullup(second_port_pullup),
    .osc_feedback_active(osc_feedback_active), .wake_request(wake_request));

/* gpc_pins_model.sv */
// Board model of one 8-bit port: pad drivers, pull-ups and external switches.
`timescale 1ns/1ps
module gpc_pins_model (
    input wire logic aclk,
    input wire gpc_pkg::gpc_pad_s pad,
    input wire logic [7:0] pull_on,
    input wire logic [7:0] ext_drive,
    input wire logic [7:0] ext_val,
    output logic [7:0] level
);
    logic [7:0] float_r = 8'h55;
    // A floating pin wanders every cycle so that a stale level is never mistaken for a real one.
    always_ff @(posedge aclk) begin
        float_r <= ~float_r;
    end
    // Device drive wins, then a switch, then the weak pull-up.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            level[i] = pad.oe[i] ? pad.out[i] : ext_drive[i] ? ext_val[i] : pull_on[i] ? 1'b1 : float_r[i];
        end
    end
endmodule // gpc_pins_model

/* gpc_port_bench.sv */
// Self-checking bench for the port block over AXI4-Lite.
`timescale 1ns/1ps
module gpc_port_bench;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, ss, rp_in, ana4, fb, wake, mm = 0, rp_drv = 0, rp_out = 0;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, rsp;
    logic [7:0] fp_lvl, sp_lvl, sp_pu, fp_val = 8'h00, sp_val = 8'hFF, ones;
    gpc_pkg::gpc_pad_s fp_pad, sp_pad;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    gpc_port i_gpc_port (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .first_port_pins_in(fp_lvl),
        .first_port_pad(fp_pad), .second_port_pins_in(sp_lvl), .second_port_pad(sp_pad),
        .second_port_pullup(sp_pu), .mem_to_mem_move(mm), .remap_pin_two_drive(rp_drv),
        .remap_pin_two_out(rp_out), .remap_pin_two_in(rp_in), .serial1_slave_select(ss),
        .analog_channel_four_en(ana4), .osc_feedback_active(fb), .wake_request(wake));
    // The first port has no pull-ups; the switches drive every pin that the device leaves undriven, so none float.
    gpc_pins_model i_fp_pins (.aclk(aclk), .pad(fp_pad), .pull_on(8'h00), .ext_drive(8'hFF), .ext_val(fp_val),
        .level(fp_lvl));
    gpc_pins_model i_sp_pins (.aclk(aclk), .pad(sp_pad), .pull_on(sp_pu), .ext_drive(8'hFF), .ext_val(sp_val),
        .level(sp_lvl));
    // Clock at 100 MHz.
    initial begin
        forever #5 aclk = ~aclk;
    end
    // The whole run needs well under two thousand cycles.
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            test_done();
        end
    end
    task automatic test_done();
        if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Requests start after a rising edge; ready and valid are sampled at the edge that moves the item.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        // The answer is left waiting one cycle so that the slave must hold it.
        @(posedge aclk);
        bready <= 1'b1;
        do @(posedge aclk); while (bvalid !== 1'b1);
        rsp = bresp;
        bready <= 1'b0;
        @(negedge aclk);
    endtask
    task automatic rd(input logic [5:0] a, input logic [7:0] exp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        @(posedge aclk);
        rready <= 1'b1;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rsp = rresp;
        chk(rdata, {24'h00_0000, exp});
        rready <= 1'b0;
        @(negedge aclk);
    endtask
    // Main sequence.
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(negedge aclk);
        rd(gpc_pkg::OFF_FP_DIR, 8'hEF);
        rd(gpc_pkg::OFF_SP_DIR, 8'hFF);
        rd(gpc_pkg::OFF_INT_TWO, 8'h80);
        chk(sp_pu, 8'h00);
        chk(ana4, 1'b1);
        rd(gpc_pkg::OFF_SP_PINS, 8'hF0);
        rd(6'h3C, 8'h00);
        chk(rsp, gpc_pkg::RESP_SLVERR);
        wr(6'h3C, 8'h00);
        chk(rsp, gpc_pkg::RESP_SLVERR);
        wr(gpc_pkg::OFF_SP_LATCH, 8'h5A);
        chk(rsp, gpc_pkg::RESP_OKAY);
        wr(gpc_pkg::OFF_SP_DIR, 8'hF0);
        rd(gpc_pkg::OFF_SP_LATCH, 8'h5A);
        chk(sp_pad.oe, 8'h0F);
        chk(sp_pad.out[3:0], 4'hA);
        wr(gpc_pkg::OFF_INT_TWO, 8'h00);
        chk(sp_pu, 8'hF0);
        wr(gpc_pkg::OFF_INT_TWO, 8'h80);
        chk(sp_pu, 8'h00);
        // Change detection: mismatch, refused clear, read, clear, then a memory move that must not count.
        rd(gpc_pkg::OFF_SP_PINS, 8'hF0);
        wr(gpc_pkg::OFF_INT_ONE, 8'h00);
        chk(wake, 1'b0);
        @(posedge aclk) sp_val <= 8'hBF;
        repeat (6) @(negedge aclk);
        chk(wake, 1'b1);
        wr(gpc_pkg::OFF_INT_ONE, 8'h00);
        chk(wake, 1'b1);
        rd(gpc_pkg::OFF_SP_PINS, 8'hB0);
        wr(gpc_pkg::OFF_INT_ONE, 8'h00);
        chk(wake, 1'b0);
        @(posedge aclk) begin
            mm <= 1'b1;
            sp_val <= 8'hFF;
        end
        repeat (6) @(negedge aclk);
        rd(gpc_pkg::OFF_SP_PINS, 8'hF0);
        wr(gpc_pkg::OFF_INT_ONE, 8'h00);
        chk(wake, 1'b1);
        @(posedge aclk) mm <= 1'b0;
        rd(gpc_pkg::OFF_SP_PINS, 8'hF0);
        wr(gpc_pkg::OFF_INT_ONE, 8'h00);
        chk(wake, 1'b0);
        wr(gpc_pkg::OFF_SP_DIR, 8'h70);
        wr(gpc_pkg::OFF_SP_LATCH, 8'hDA);
        repeat (6) @(negedge aclk);
        chk(wake, 1'b0);
        // First port pin 5: digital input feeding serial select, then peripheral output.
        wr(gpc_pkg::OFF_ANA_LOW, 8'h10);
        chk(ana4, 1'b0);
        repeat (6) @(negedge aclk);
        chk({ss, rp_in}, 2'b00);
        @(posedge aclk) fp_val <= 8'h20;
        repeat (6) @(negedge aclk);
        chk({ss, rp_in}, 2'b11);
        wr(gpc_pkg::OFF_FP_LATCH, 8'hFF);
        rd(gpc_pkg::OFF_FP_LATCH, 8'hEF);
        @(posedge aclk) rp_drv <= 1'b1;
        wr(gpc_pkg::OFF_FP_DIR, 8'h0F);
        repeat (2) @(negedge aclk);
        chk(fp_pad.oe, 8'hE0);
        chk({fp_pad.out[7:5], ss}, 4'b1101);
        // Oscillator modes decide what pins 6 and 7 do.
        for (int m = 0; m < 4; m++) begin
            wr(gpc_pkg::OFF_OSC_MODE, m[7:0]);
            repeat (2) @(negedge aclk);
            chk(fb, m == 1);
            chk(fp_pad.oe[7], m == 0);
            ones = 8'h00;
            repeat (8) @(negedge aclk) ones += fp_pad.out[6];
            chk({fp_pad.oe[6], ones}, m == 1 ? 9'h000 : m == 0 ? 9'h108 : 9'h104);
        end
        test_done();
    end
endmodule // gpc_port_bench
